// File: logic/header_byte_decode.sv
`timescale 1ns/10ps
// maps an offset to one of the four header bytes
module header_byte_decode (
  input  wire logic [15:0] offset_in,
  input  wire logic [15:0] base_in,
  output logic             hit_out,
  output logic [1:0]       index_out
);
  import header_misc_pkg::*;

  logic [15:0] delta; // distance from the first byte

  // low two bits pick the byte once the offset lies in the block
  always_comb begin
    delta     = offset_in - base_in;
    hit_out   = (delta < 16'h0004);
    index_out = delta[1:0];
  end
endmodule // header_byte_decode

// File: logic/header_misc_pkg.sv
package header_misc_pkg;

  // configuration space offsets of the four header bytes
  localparam logic [7:0] CFG_OFF_CACHELINE  = 8'h0C;
  localparam logic [7:0] CFG_OFF_LATENCY    = 8'h0D;
  localparam logic [7:0] CFG_OFF_HEADER     = 8'h0E;
  localparam logic [7:0] CFG_OFF_SELF_TEST  = 8'h0F;

  // local processor bus addresses of the same bytes
  localparam logic [15:0] LOCAL_OFF_CACHELINE = 16'h120C;
  localparam logic [15:0] LOCAL_OFF_LATENCY   = 16'h120D;
  localparam logic [15:0] LOCAL_OFF_HEADER    = 16'h120E;
  localparam logic [15:0] LOCAL_OFF_SELF_TEST = 16'h120F;

  // values after reset
  localparam logic [7:0] CACHELINE_RESET   = 8'h00;
  localparam logic [4:0] LATENCY_RESET     = 5'h00;
  localparam logic [3:0] COMPLETION_RESET  = 4'h0;

  // honoured cacheline sizes, in 32-bit words
  localparam logic [7:0] CACHELINE_WORDS_8  = 8'h08;
  localparam logic [7:0] CACHELINE_WORDS_16 = 8'h10;

  // field positions
  localparam int LATENCY_FIELD_LSB  = 3;
  localparam int SELF_TEST_CAP_BIT  = 7;
  localparam int SELF_TEST_START    = 6;
  localparam int MULTI_FUNCTION_BIT = 7;

  // fixed read values
  localparam logic [2:0] LATENCY_GRANULE_BITS = 3'h0;
  localparam logic       MULTI_FUNCTION_FLAG  = 1'b0;
  localparam logic [6:0] HEADER_LAYOUT_CODE   = 7'h00;

  // one byte access from a register port
  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } byte_access_type;

  // register state of the bank
  typedef struct packed {
    logic [7:0]  cacheline;
    logic [4:0]  latency;
    logic        start;
    logic [3:0]  completion;
    logic        irq;
    logic [7:0]  cfg_rdata;
    logic [7:0]  local_rdata;
    logic        cfg_hit;
    logic        local_hit;
  } bank_state_type;

endpackage

// File: logic/header_misc_regs.sv
`timescale 1ns/10ps
// Operation
// R1: bytes reachable at local and configuration offsets
// R2: cacheline size 8-bit read/write, resets zero
// R3: only 8 or 16 honoured, else zero
// R4: latency upper five bits writable, 0..248
// R5: latency low three bits read zero
// R6: header bit 7 reads zero, single function
// R7: header bits 6..0 report type 00H
// R8: self-test bit 7 mirrors interrupt enable
// R9: start with enable raises core interrupt
// R10: core clears start after placing result
// R11: start without enable: no interrupt, stays
// R12: completion code holds core result, zero passes
// R13: self-test bits 5 and 4 read zero
// R14: start and completion reset to zero
module header_misc_regs (
  input  wire logic                             clk_sys_in,
  input  wire logic                             rst_in,
  input  wire header_misc_pkg::byte_access_type cfg_access_in,
  input  wire header_misc_pkg::byte_access_type local_access_in,
  input  wire logic                             self_test_int_enable_in,
  output logic [7:0]                            cfg_rdata_out,
  output logic                                  cfg_hit_out,
  output logic [7:0]                            local_rdata_out,
  output logic                                  local_hit_out,
  output logic [7:0]                            cacheline_effective_out,
  output logic [7:0]                            latency_clocks_out,
  output logic                                  self_test_irq_out
);
  import header_misc_pkg::*;

  bank_state_type state;       // registered bank
  bank_state_type next_state;  // value for the next edge
  logic           cfg_sel;     // configuration access in block
  logic [1:0]     cfg_idx;     // configuration byte index
  logic           local_sel;   // local access in block
  logic [1:0]     local_idx;   // local byte index
  logic           start_rise;  // start bit newly set

  // read value of one header byte
  function automatic logic [7:0] read_byte(input bank_state_type s, input logic [1:0] idx,
                                            input logic en);
    logic [7:0] val;
    val = 8'h00;
    if (idx == 2'd0) begin
      val = s.cacheline;
    end else if (idx == 2'd1) begin
      val = {s.latency, LATENCY_GRANULE_BITS}; // see R4 see R5
    end else if (idx == 2'd2) begin
      val = {MULTI_FUNCTION_FLAG, HEADER_LAYOUT_CODE}; // see R6 see R7
    end else begin
      val = {en, s.start, 2'b00, s.completion}; // see R8 see R13
    end
    return val;
  endfunction

  // both ports decode the same four bytes
  header_byte_decode cfg_decode (
    .offset_in (cfg_access_in.addr),
    .base_in   ({8'h00, CFG_OFF_CACHELINE}),
    .hit_out   (cfg_sel),
    .index_out (cfg_idx)
  );

  header_byte_decode local_decode (
    .offset_in (local_access_in.addr),
    .base_in   (LOCAL_OFF_CACHELINE),
    .hit_out   (local_sel),
    .index_out (local_idx)
  );

  // next state: local write applied after host write, so the core wins a same-cycle clash
  always_comb begin
    next_state = state;
    if (cfg_access_in.write && cfg_sel) begin // see R1
      if (cfg_idx == 2'd0) begin
        next_state.cacheline = cfg_access_in.wdata; // see R2
      end else if (cfg_idx == 2'd1) begin
        next_state.latency = cfg_access_in.wdata[7:LATENCY_FIELD_LSB]; // see R4
      end else if (cfg_idx == 2'd3) begin
        next_state.start      = cfg_access_in.wdata[SELF_TEST_START];
        next_state.completion = cfg_access_in.wdata[3:0];
      end
    end
    if (local_access_in.write && local_sel) begin // see R1
      if (local_idx == 2'd0) begin
        next_state.cacheline = local_access_in.wdata; // see R2
      end else if (local_idx == 2'd1) begin
        next_state.latency = local_access_in.wdata[7:LATENCY_FIELD_LSB];
      end else if (local_idx == 2'd3) begin
        // core clears start with its result in place
        next_state.start      = local_access_in.wdata[SELF_TEST_START]; // see R10
        next_state.completion = local_access_in.wdata[3:0]; // see R12
      end
    end
    // rise worked out here from this process's own result, so nothing loops through an assign
    start_rise = next_state.start && !state.start;
    // single-cycle pulse to the core, registered on the edge where start goes high
    next_state.irq = start_rise && self_test_int_enable_in; // see R9 see R11
    next_state.cfg_rdata   = read_byte(state, cfg_idx, self_test_int_enable_in);
    next_state.local_rdata = read_byte(state, local_idx, self_test_int_enable_in);
    next_state.cfg_hit     = cfg_access_in.read && cfg_sel;
    next_state.local_hit   = local_access_in.read && local_sel;
    if (!next_state.cfg_hit) begin
      next_state.cfg_rdata = 8'h00;
    end
    if (!next_state.local_hit) begin
      next_state.local_rdata = 8'h00;
    end
  end

  // registered copy
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state            <= '0;
      state.cacheline  <= CACHELINE_RESET; // see R2
      state.latency    <= LATENCY_RESET;
      state.start      <= 1'b0; // see R14
      state.completion <= COMPLETION_RESET; // see R14
    end else begin
      state <= next_state;
    end
  end

  // only 8 or 16 words reach the rest of the unit
  always_comb begin
    if (state.cacheline == CACHELINE_WORDS_8 || state.cacheline == CACHELINE_WORDS_16) begin
      cacheline_effective_out = state.cacheline; // see R3
    end else begin
      cacheline_effective_out = 8'h00; // see R3
    end
  end

  assign latency_clocks_out = {state.latency, LATENCY_GRANULE_BITS}; // see R4
  assign cfg_rdata_out      = state.cfg_rdata;
  assign cfg_hit_out        = state.cfg_hit;
  assign local_rdata_out    = state.local_rdata;
  assign local_hit_out      = state.local_hit;
  assign self_test_irq_out  = state.irq;

  // start and its pulse are registered on the same edge, so the pulse stands with start
  sequence start_set_s;
    !state.start ##1 state.start;
  endsequence
  irq_on_start_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R9
    (start_set_s ##0 $past(self_test_int_enable_in)) |-> self_test_irq_out ##1 !self_test_irq_out)
    else $error("start with enable gave no single interrupt pulse");

  no_irq_disabled_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R11
    self_test_irq_out |-> state.start && !$past(state.start) && $past(self_test_int_enable_in))
    else $error("interrupt without enable or start");

  start_held_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R11
    (state.start && !(local_access_in.write && local_sel && local_idx == 2'd3)
     && !(cfg_access_in.write && cfg_sel && cfg_idx == 2'd3)) |=> state.start)
    else $error("start bit dropped without a write");

  cacheline_filter_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R3
    (cacheline_effective_out != 8'h00) |-> (state.cacheline == CACHELINE_WORDS_8 ||
                                           state.cacheline == CACHELINE_WORDS_16))
    else $error("unsupported cacheline size honoured");

  latency_low_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R4 R5
    (cfg_access_in.read && cfg_sel && cfg_idx == 2'd1) |=> cfg_rdata_out[2:0] == 3'h0
      && cfg_rdata_out[7:3] == $past(state.latency))
    else $error("latency readback wrong");

  header_type_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R6 R7
    (local_access_in.read && local_sel && local_idx == 2'd2) |=> local_rdata_out == 8'h00)
    else $error("header type byte not zero");

  self_test_read_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R8 R13
    (cfg_access_in.read && cfg_sel && cfg_idx == 2'd3) |=>
      cfg_rdata_out[7] == $past(self_test_int_enable_in) && cfg_rdata_out[5:4] == 2'b00)
    else $error("self-test capability or reserved bits wrong");

  reset_clear_a: assert property (@(posedge clk_sys_in) // see R2 R14
    rst_in |=> !state.start && state.completion == 4'h0 && state.cacheline == 8'h00)
    else $error("bank not cleared by reset");

  completion_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R12
    (local_access_in.write && local_sel && local_idx == 2'd3) |=>
      state.completion == $past(local_access_in.wdata[3:0]))
    else $error("completion code not stored");

  dual_port_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see R1 R2
    (cfg_access_in.write && cfg_sel && cfg_idx == 2'd0 && !(local_access_in.write && local_sel))
      |=> state.cacheline == $past(cfg_access_in.wdata))
    else $error("configuration write to cacheline lost");
endmodule // header_misc_regs

// File: tb/core_model.sv
`timescale 1ns/10ps
// behavioural local core: answers a self-test interrupt with a result
module core_model
  import header_misc_pkg::*;
#(
  parameter logic [3:0] CODE  = 4'h5,  // result placed in the completion code
  parameter int         DELAY = 3      // cycles the software test takes
) (
  input  wire logic            clk_sys_in,
  input  wire logic            irq_in,
  output byte_access_type      access_out
);
  // one write clears start and carries the result in the same byte
  initial begin
    access_out = '0;
    forever begin
      @(posedge clk_sys_in);
      #1;
      if (irq_in === 1'b1) begin
        repeat (DELAY) @(posedge clk_sys_in);
        #1 access_out = '{1'b0, 1'b1, LOCAL_OFF_SELF_TEST, {4'h0, CODE}};
        @(posedge clk_sys_in);
        #1 access_out = '0;
      end
    end
  end
endmodule // core_model

// File: tb/header_misc_regs_test.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %0t got %h expected %h", $time, got, exp); end end
module header_misc_regs_test;
  import header_misc_pkg::*;
  logic            clk_sys_in = 1'b0;  // system clock
  logic            rst_in     = 1'b1;  // synchronous reset
  byte_access_type cfg_acc    = '0;    // host port
  byte_access_type tb_local   = '0;    // bench side of local port
  byte_access_type core_acc;           // core model side of local port
  byte_access_type local_acc;          // merged local port
  logic            enable     = 1'b0;  // self-test interrupt enable
  logic [7:0]      cfg_rdata, local_rdata, eff, lat;
  logic            cfg_hit, local_hit, irq;
  int              err_total = 0, checks = 0, cycles = 0, irq_count = 0, i, n;
  logic [7:0]      cl_vals [4] = '{8'h08, 8'h10, 8'h07, 8'hFF};
  always #2 clk_sys_in = ~clk_sys_in;
  // core drives only while writing back, so the bench never collides
  assign local_acc = core_acc.write ? core_acc : tb_local;
  header_misc_regs i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_access_in(cfg_acc),
    .local_access_in(local_acc), .self_test_int_enable_in(enable), .cfg_rdata_out(cfg_rdata),
    .cfg_hit_out(cfg_hit), .local_rdata_out(local_rdata), .local_hit_out(local_hit),
    .cacheline_effective_out(eff), .latency_clocks_out(lat), .self_test_irq_out(irq));
  core_model #(.CODE(4'h5), .DELAY(3)) i_core (.clk_sys_in(clk_sys_in), .irq_in(irq),
    .access_out(core_acc));
  // interrupt pulses and hang guard, looked at mid-cycle where the pulse is settled
  always @(negedge clk_sys_in) begin
    cycles++;
    if (irq === 1'b1) irq_count++;
    if (cycles == 2000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle strobe; a gap cycle first so no signal is set twice at once
  task automatic xfer(input bit loc, input bit wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    if (loc) tb_local = '{~wr, wr, a, d};
    else cfg_acc = '{~wr, wr, a, d};
    @(posedge clk_sys_in);
    #1;
    tb_local = '0;
    cfg_acc  = '0;
  endtask
  // hit and data stand just after the taking edge, which registers them
  task automatic rd(input bit loc, input logic [15:0] a, input logic hit, input logic [7:0] d);
    xfer(loc, 1'b0, a, 8'h00);
    `CHK(loc ? local_hit : cfg_hit, hit)
    `CHK(loc ? local_rdata : cfg_rdata, d)
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1 rst_in = 1'b0;
    // reset values of all four bytes
    for (i = 0; i < 4; i++) rd(1'b0, 16'h000C + i[15:0], 1'b1, 8'h00);
    `CHK(eff, 8'h00)
    `CHK(lat, 8'h00)
    // only 8 or 16 words survive as the effective size
    for (i = 0; i < 4; i++) begin
      xfer(1'b0, 1'b1, {8'h00, CFG_OFF_CACHELINE}, cl_vals[i]);
      `CHK(eff, (i < 2) ? cl_vals[i] : 8'h00)
      rd(1'b1, LOCAL_OFF_CACHELINE, 1'b1, cl_vals[i]);
    end
    xfer(1'b1, 1'b1, LOCAL_OFF_LATENCY, 8'hFF);
    `CHK(lat, 8'hF8)
    rd(1'b0, {8'h00, CFG_OFF_LATENCY}, 1'b1, 8'hF8);
    xfer(1'b0, 1'b1, {8'h00, CFG_OFF_HEADER}, 8'hFF);
    rd(1'b1, LOCAL_OFF_HEADER, 1'b1, 8'h00);
    // out-of-block addresses are ignored on both ports
    rd(1'b0, 16'h0010, 1'b0, 8'h00);
    rd(1'b1, 16'h000C, 1'b0, 8'h00);
    // start without enable: no interrupt, start stays, reserved bits read zero
    n = irq_count;
    xfer(1'b0, 1'b1, {8'h00, CFG_OFF_SELF_TEST}, 8'h7F);
    repeat (8) @(posedge clk_sys_in);
    `CHK(irq_count - n, 0)
    rd(1'b0, {8'h00, CFG_OFF_SELF_TEST}, 1'b1, 8'h4F);
    xfer(1'b0, 1'b1, {8'h00, CFG_OFF_SELF_TEST}, 8'h00);
    // with enable: one pulse, core writes back result and clears start
    enable = 1'b1;
    rd(1'b0, {8'h00, CFG_OFF_SELF_TEST}, 1'b1, 8'h80);
    n = irq_count;
    xfer(1'b0, 1'b1, {8'h00, CFG_OFF_SELF_TEST}, 8'h40);
    repeat (12) @(posedge clk_sys_in);
    `CHK(irq_count - n, 1)
    rd(1'b1, LOCAL_OFF_SELF_TEST, 1'b1, 8'h85);
    finish_test();
  end
endmodule // header_misc_regs_test
